// ==== rtl/irq_intake_agent.sv ====
`timescale 1ns/1ns
module irq_intake_agent (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             o_irq,
  // link
  irq_intake_if.agent      link
);
  logic [3:0]  target_reg,  target_next;
  logic [4:0]  wr_en_reg,   wr_en_next;
  logic [4:0]  value_reg,   value_next;
  logic        send_reg,    send_next;
  logic        nmi_reg,     nmi_next;
  logic [1:0]  nmi_cnt_reg, nmi_cnt_next;
  logic [1:0]  stat_reg,    stat_next;
  logic [1:0]  mask_reg,    mask_next;
  logic        wr;
  logic [1:0]  ev;

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb
  begin
    target_next  = target_reg;
    wr_en_next   = wr_en_reg;
    value_next   = value_reg;
    mask_next    = mask_reg;
    nmi_next     = nmi_reg;
    nmi_cnt_next = nmi_cnt_reg;
    send_next    = 1'b0;
    ev           = 2'h0;
    if (send_reg)
      ev[irq_intake_pkg::IRQ_EV_SENT] = 1'b1;
    // nmi held two cycles then negated
    if (nmi_reg)
    begin
      nmi_cnt_next = nmi_cnt_reg + 2'h1;
      if (nmi_cnt_reg == 2'h1)
      begin
        nmi_next = 1'b0;
        ev[irq_intake_pkg::IRQ_EV_NMI_DONE] = 1'b1;
      end
    end
    if (wr)
    begin
      case (paddr)
        irq_intake_pkg::OFS_CMD:      send_next  = pwdata[0];
        irq_intake_pkg::OFS_TARGET:   target_next = pwdata[3:0];
        irq_intake_pkg::OFS_WR_EN:    wr_en_next = pwdata[4:0];
        irq_intake_pkg::OFS_VALUE:    value_next = pwdata[4:0];
        irq_intake_pkg::OFS_NMI:
        begin
          if (pwdata[0] && !nmi_reg)
          begin
            nmi_next     = 1'b1;
            nmi_cnt_next = 2'h0;
          end
        end
        irq_intake_pkg::OFS_IRQ_MASK: mask_next  = pwdata[1:0];
        default: ;
      endcase
    end
    stat_next = stat_reg | ev;
    if (wr && paddr == irq_intake_pkg::OFS_IRQ_STAT)
      stat_next = (stat_reg & ~pwdata[1:0]) | ev;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      target_reg  <= 4'h0;
      wr_en_reg   <= 5'h00;
      value_reg   <= 5'h00;
      send_reg    <= 1'b0;
      nmi_reg     <= 1'b0;
      nmi_cnt_reg <= 2'h0;
      stat_reg    <= 2'h0;
      mask_reg    <= 2'h0;
    end
    else
    begin
      target_reg  <= target_next;
      wr_en_reg   <= wr_en_next;
      value_reg   <= value_next;
      send_reg    <= send_next;
      nmi_reg     <= nmi_next;
      nmi_cnt_reg <= nmi_cnt_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
    end
  end

  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      irq_intake_pkg::OFS_TARGET:   prdata = {28'h0, target_reg};
      irq_intake_pkg::OFS_WR_EN:    prdata = {27'h0, wr_en_reg};
      irq_intake_pkg::OFS_VALUE:    prdata = {27'h0, value_reg};
      irq_intake_pkg::OFS_STATUS:   prdata = {30'h0, nmi_reg, send_reg};
      irq_intake_pkg::OFS_IRQ_STAT: prdata = {30'h0, stat_reg};
      irq_intake_pkg::OFS_IRQ_MASK: prdata = {30'h0, mask_reg};
      default:                      prdata = 32'h0;
    endcase
  end

  assign o_irq = |(stat_reg & mask_reg);

  // one-cycle address cycle
  always_comb
  begin
    link.system_addr_data_bus = 64'h0;
    link.system_addr_data_bus[irq_intake_pkg::TARGET_LSB +: 4] = target_reg;
    link.system_addr_data_bus[irq_intake_pkg::WR_EN_LSB +: 5]  = wr_en_reg;
    link.system_addr_data_bus[irq_intake_pkg::VALUE_LSB +: 5]  = value_reg;
  end
  assign link.int_req_valid     = send_reg;
  assign link.nonmaskable_irq_n = ~nmi_reg;
endmodule : irq_intake_agent

// ==== rtl/irq_intake_device.sv ====
`timescale 1ns/1ns
module irq_intake_device #(
  parameter logic [1:0] DEVICE_NUMBER = 2'h0
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_soft_reset,
  // link
  irq_intake_if.device     link,
  // cop0 software write
  input  wire logic        i_cop0_move_write,
  input  wire logic [1:0]  i_sw_irq_value,
  // timer sources
  input  wire logic        i_count_eq_compare,
  input  wire logic [1:0]  i_perf_overflow,
  input  wire logic        i_timer_clear,
  // status
  output logic [15:0]      o_cause_ip,
  output logic             o_nmi_posted
);
  localparam int unsigned HW = irq_intake_pkg::HW_IRQ_COUNT;
  localparam int unsigned SW = irq_intake_pkg::SW_IRQ_COUNT;

  // the cause fields must not overlap, nor the link write enables and target field
  if (irq_intake_pkg::CAUSE_HW_LSB + HW > irq_intake_pkg::CAUSE_TIMER_BIT)
  begin : g_bad_hw_field
    $error("hw field overlaps the timer bit");
  end
  if (irq_intake_pkg::CAUSE_SW_LSB + SW > irq_intake_pkg::CAUSE_HW_LSB)
  begin : g_bad_sw_field
    $error("sw field overlaps the hw field");
  end
  if (irq_intake_pkg::WR_EN_LSB + HW > irq_intake_pkg::TARGET_LSB)
  begin : g_bad_enable_field
    $error("write enables overlap the target field");
  end
  if (32'(DEVICE_NUMBER) >= irq_intake_pkg::TARGET_COUNT)
  begin : g_bad_device_number
    $error("device number has no target bit");
  end

  logic [HW-1:0] hw_irq_reg;
  logic [HW-1:0] hw_irq_next;
  logic [HW-1:0] hw_bit_new;
  logic [1:0]    sw_irq_reg;
  logic [1:0]    sw_irq_next;
  logic          timer_reg;
  logic          timer_next;
  logic          targeted;
  logic [HW-1:0] wr_en;
  logic [HW-1:0] wr_val;

  // device number picks target bit 60+n
  assign targeted = link.int_req_valid & link.system_addr_data_bus[
    irq_intake_pkg::TARGET_LSB + 32'(DEVICE_NUMBER)];
  assign wr_en  = link.system_addr_data_bus[
    irq_intake_pkg::WR_EN_LSB +: HW];
  assign wr_val = link.system_addr_data_bus[
    irq_intake_pkg::VALUE_LSB +: HW];

  // a bit moves only when targeted and enabled
  for (genvar g = 0; g < HW; g++)
  begin : g_hw_bit
    assign hw_bit_new[g] = (targeted & wr_en[g]) ? wr_val[g] : hw_irq_reg[g];
  end

  // hardware interrupt bits
  always_comb
  begin
    hw_irq_next = hw_bit_new;
    // soft reset clears hw bits too
    if (i_soft_reset)
      hw_irq_next = irq_intake_pkg::HW_IRQ_RESET;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      hw_irq_reg <= irq_intake_pkg::HW_IRQ_RESET;
    else
      hw_irq_reg <= hw_irq_next;
  end

  // software interrupt bits
  always_comb
  begin
    sw_irq_next = sw_irq_reg;
    if (i_cop0_move_write)
      sw_irq_next = i_sw_irq_value;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      sw_irq_reg <= irq_intake_pkg::SW_IRQ_RESET;
    else
      sw_irq_reg <= sw_irq_next;
  end

  // timer bit
  always_comb
  begin
    // set wins over clear
    timer_next = (timer_reg & ~i_timer_clear) | i_count_eq_compare |
                 (|i_perf_overflow);
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      timer_reg <= 1'b0;
    else
      timer_reg <= timer_next;
  end

  // cause layout
  always_comb
  begin
    o_cause_ip = '0;
    o_cause_ip[irq_intake_pkg::CAUSE_HW_LSB +: HW] = hw_irq_reg;
    o_cause_ip[irq_intake_pkg::CAUSE_SW_LSB +: 2]  = sw_irq_reg;
    o_cause_ip[irq_intake_pkg::CAUSE_TIMER_BIT]    = timer_reg;
  end

  nmi_edge_detect u_nmi (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_line_n  (link.nonmaskable_irq_n),
    .o_posted  (o_nmi_posted)
  );
endmodule : irq_intake_device

// ==== rtl/irq_intake_if.sv ====
`timescale 1ns/1ns
interface irq_intake_if;
  logic [63:0] system_addr_data_bus;
  logic        int_req_valid;
  logic        nonmaskable_irq_n;
  modport device (
    input system_addr_data_bus,
    input int_req_valid,
    input nonmaskable_irq_n
  );
  modport agent (
    output system_addr_data_bus,
    output int_req_valid,
    output nonmaskable_irq_n
  );
endinterface : irq_intake_if

// ==== rtl/irq_intake_pkg.sv ====
package irq_intake_pkg;
  localparam int unsigned ADDR_DATA_W     = 64;
  localparam int unsigned HW_IRQ_COUNT    = 5;
  localparam int unsigned SW_IRQ_COUNT    = 2;
  localparam int unsigned TARGET_LSB      = 60;
  localparam int unsigned TARGET_COUNT    = 4;
  localparam int unsigned WR_EN_LSB       = 16;
  localparam int unsigned VALUE_LSB       = 0;
  localparam int unsigned CAUSE_HW_LSB    = 10;
  localparam int unsigned CAUSE_SW_LSB    = 8;
  localparam int unsigned CAUSE_TIMER_BIT = 15;
  localparam int unsigned CAUSE_W         = 16;
  localparam int unsigned COUNTER_W       = 32;
  localparam logic [4:0]  HW_IRQ_RESET    = 5'h00;
  localparam logic [1:0]  SW_IRQ_RESET    = 2'h0;
  // agent apb register offsets
  localparam logic [7:0]  OFS_CMD         = 8'h00;
  localparam logic [7:0]  OFS_TARGET      = 8'h04;
  localparam logic [7:0]  OFS_WR_EN       = 8'h08;
  localparam logic [7:0]  OFS_VALUE       = 8'h0c;
  localparam logic [7:0]  OFS_NMI         = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1c;
  localparam int unsigned IRQ_EV_SENT     = 0;
  localparam int unsigned IRQ_EV_NMI_DONE = 1;
endpackage : irq_intake_pkg

// ==== rtl/nmi_edge_detect.sv ====
`timescale 1ns/1ns
module nmi_edge_detect (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // line
  input  wire logic i_line_n,
  // event
  output logic      o_posted
);
  logic armed_reg;
  logic armed_next;

  // re-arms only after the line is seen negated
  always_comb
  begin
    armed_next = ~i_line_n ? 1'b0 : 1'b1;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      armed_reg <= 1'b1;
    else
      armed_reg <= armed_next;
  end

  // first cycle of assertion
  assign o_posted = armed_reg & ~i_line_n;
endmodule : nmi_edge_detect

// ==== verif/irq_intake_chk.sv ====
`timescale 1ns/1ns
module irq_intake_chk (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        i_soft_reset,
  // link
  input wire logic [63:0] system_addr_data_bus,
  input wire logic        int_req_valid,
  input wire logic        nonmaskable_irq_n,
  // device status
  input wire logic [15:0] o_cause_ip,
  input wire logic        o_nmi_posted
);
  logic [63:0] bus;
  logic        hit;
  assign bus = system_addr_data_bus;
  assign hit = int_req_valid && bus[60] && !i_soft_reset;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_nmi_tail;
    !nonmaskable_irq_n ##1 nonmaskable_irq_n;
  endsequence
  property p_fields;
    int_req_valid |-> bus[59:21] == 39'h0 && bus[15:5] == 11'h000;
  endproperty
  property p_set;
    hit |=> ((o_cause_ip[14:10] ^ $past(bus[4:0]))
      & $past(bus[20:16])) == 5'h00;
  endproperty
  property p_keep;
    hit |=> ((o_cause_ip[14:10] ^ $past(o_cause_ip[14:10]))
      & ~$past(bus[20:16])) == 5'h00;
  endproperty
  property p_idle;
    !(int_req_valid && bus[60]) && !i_soft_reset
      |=> $stable(o_cause_ip[14:10]);
  endproperty
  property p_soft;
    i_soft_reset |=> o_cause_ip[14:10] == 5'h00;
  endproperty
  property p_nmi_see;
    $fell(nonmaskable_irq_n) |-> o_nmi_posted;
  endproperty
  property p_nmi_once;
    o_nmi_posted |=> !o_nmi_posted;
  endproperty
  property p_nmi_width;
    $fell(nonmaskable_irq_n) |=> s_nmi_tail;
  endproperty
  property p_zero;
    o_cause_ip[7:0] == 8'h00;
  endproperty
  a_fields: assert property (p_fields)
    else $error("bad request fields");
  a_set: assert property (p_set)
    else $error("hw bit not written");
  a_keep: assert property (p_keep)
    else $error("hw bit changed");
  a_idle: assert property (p_idle)
    else $error("hw bits moved");
  a_soft: assert property (p_soft)
    else $error("soft reset kept bits");
  a_nmi_see: assert property (p_nmi_see)
    else $error("nmi missed");
  a_nmi_once: assert property (p_nmi_once)
    else $error("nmi twice");
  a_nmi_width: assert property (p_nmi_width)
    else $error("nmi width");
  a_zero: assert property (p_zero)
    else $error("low cause bits set");
endmodule : irq_intake_chk

// ==== verif/processor_interrupt_intake_test.sv ====
`timescale 1ns/1ns
module processor_interrupt_intake_test;
  logic        i_clk_sys = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_soft_reset = 1'b0;
  logic        i_cop0_move_write = 1'b0;
  logic [1:0]  i_sw_irq_value = 2'h0;
  logic        i_count_eq_compare = 1'b0;
  logic [1:0]  i_perf_overflow = 2'h0;
  logic        i_timer_clear = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [15:0] o_cause_ip;
  logic        pready, pslverr, o_nmi_posted, o_irq;
  int          errors = 0, cmp_count = 0, posts = 0;
  irq_intake_if link_if ();
  always #5 i_clk_sys = ~i_clk_sys;
  irq_intake_device irq_intake_device_i (.i_clk_sys, .i_reset, .i_soft_reset,
    .link(link_if.device), .i_cop0_move_write, .i_sw_irq_value,
    .i_count_eq_compare, .i_perf_overflow, .i_timer_clear, .o_cause_ip,
    .o_nmi_posted);
  irq_intake_agent irq_intake_agent_i (.i_clk_sys, .i_reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .o_irq,
    .link(link_if.agent));
  irq_intake_chk irq_intake_chk_i (.i_clk_sys, .i_reset, .i_soft_reset,
    .system_addr_data_bus(link_if.system_addr_data_bus),
    .int_req_valid(link_if.int_req_valid),
    .nonmaskable_irq_n(link_if.nonmaskable_irq_n), .o_cause_ip,
    .o_nmi_posted);
  task automatic results;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    @(posedge i_clk_sys);
    while (pready !== 1'b1)
      @(posedge i_clk_sys);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic req(input logic [3:0] t, input logic [4:0] en, v,
                     input logic [15:0] e);
    apb(1'b1, irq_intake_pkg::OFS_TARGET, {28'h0, t});
    apb(1'b1, irq_intake_pkg::OFS_WR_EN, {27'h0, en});
    apb(1'b1, irq_intake_pkg::OFS_VALUE, {27'h0, v});
    apb(1'b1, irq_intake_pkg::OFS_CMD, 32'h1);
    repeat (3) @(posedge i_clk_sys);
    #1 chk({16'h0, o_cause_ip}, {16'h0, e});
  endtask : req
  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_clk_sys);
    #1 chk({31'h0, o_irq}, {31'h0, e});
  endtask : irq_is
  always @(posedge i_clk_sys)
    if (o_nmi_posted === 1'b1)
      posts++;
  initial
  begin
    repeat (3000) @(posedge i_clk_sys);
    errors++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    #1 chk({16'h0, o_cause_ip}, 32'h0);
    req(4'h1, 5'h1f, 5'h15, 16'h5400);
    req(4'h1, 5'h03, 5'h00, 16'h5000);
    req(4'he, 5'h1f, 5'h0a, 16'h5000);
    req(4'h1, 5'h0a, 5'h0a, 16'h7800);
    @(posedge i_clk_sys);
    i_soft_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_soft_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk({16'h0, o_cause_ip[15:10], 10'h0}, 32'h0);
    @(posedge i_clk_sys);
    i_sw_irq_value <= 2'h2;
    i_cop0_move_write <= 1'b1;
    @(posedge i_clk_sys);
    i_cop0_move_write <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk({16'h0, o_cause_ip}, 32'h0200);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_clk_sys);
      {i_perf_overflow, i_count_eq_compare} <= 3'h1 << i;
      @(posedge i_clk_sys);
      {i_perf_overflow, i_count_eq_compare} <= 3'h0;
      @(posedge i_clk_sys);
      #1 chk({16'h0, o_cause_ip}, 32'h8200);
      @(posedge i_clk_sys);
      i_timer_clear <= 1'b1;
      @(posedge i_clk_sys);
      i_timer_clear <= 1'b0;
    end
    #1 chk({16'h0, o_cause_ip}, 32'h0200);
    apb(1'b1, irq_intake_pkg::OFS_NMI, 32'h1);
    repeat (5) @(posedge i_clk_sys);
    apb(1'b1, irq_intake_pkg::OFS_NMI, 32'h1);
    repeat (5) @(posedge i_clk_sys);
    chk(posts, 32'h2);
    apb(1'b0, irq_intake_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rdata, 32'h3);
    irq_is(1'b0);
    apb(1'b1, irq_intake_pkg::OFS_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    apb(1'b1, irq_intake_pkg::OFS_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    apb(1'b0, irq_intake_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rdata, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    results();
  end
endmodule : processor_interrupt_intake_test
